/* File: key_switch_model.sv */
// Model of the key switches and wake source outside the block
`timescale 1ns/1ps
module key_switch_model (
	input  wire logic       mclk,
	input  wire logic [3:0] keyPress,
	input  wire logic       stopLevel,
	output logic      [3:0] keyPins,
	output logic            stopPin
);
	// Idle lines at their rest levels from time zero
	initial begin
		keyPins = 4'hF;
		stopPin = 1'b0;
	end
	// Pressed keys pull low, released keys sit high on pull-ups
	always @(posedge mclk) begin
		keyPins <= ~keyPress;
		stopPin <= stopLevel;
	end
endmodule // key_switch_model

/* File: key_wakeup_stop_release.sv */
// Key-on wakeup logic that decides when the stop state is released
`timescale 1ns/1ps
module key_wakeup_stop_release
	import kwu_pkg::*;
#(
	parameter int NUM_KEYS = 4
) (
	input  wire logic                mclk,
	input  wire logic                rst,
	input  wire logic                clkEn,
	input  wire logic [15:0]         regAddr,
	input  wire logic [7:0]          regWdata,
	input  wire logic                regWr,
	input  wire logic                regRd,
	output logic      [7:0]          regRdata,
	input  wire logic                releaseMode,
	input  wire logic                stopRequest,
	input  wire logic                stopPin,
	input  wire logic [NUM_KEYS-1:0] keyPins,
	output logic      [NUM_KEYS-1:0] keyPortLevel,
	output logic                     stopActive,
	output logic                     warmupStart
);
	typedef enum logic [1:0] {
		ST_RUN  = 2'b01,
		ST_STOP = 2'b10
	} state_e;

	state_e              state_q;
	logic [NUM_KEYS-1:0] keyEnable_q;
	logic [NUM_KEYS-1:0] keyFilt;
	logic                stopFilt;
	logic                stopFiltPrev_q;
	logic                keyRelease;
	logic                levelRelease;
	logic                edgeRelease;
	logic                releaseNow;

	// Register address decode, used by the write path only
	function automatic logic hitEnable(input logic [15:0] addr);
		return addr == KEY_WAKE_ENABLE_ADDR;
	endfunction

	// ---------------------------------------------------------------
	// Input filtering
	// ---------------------------------------------------------------
	// Key pins idle high, dedicated pin idles low
	for (genvar i = 0; i < NUM_KEYS; i++) begin : g_key
		kwu_pin_filter #(.SAMPLES(FILTER_SAMPLES), .INIT(1'b1)) u_keyFilt (
			.mclk        (mclk),
			.rst         (rst),
			.clkEn       (clkEn),
			.pinIn       (keyPins[i]),
			.pinFiltered (keyFilt[i])
		);
	end

	kwu_pin_filter #(.SAMPLES(FILTER_SAMPLES), .INIT(1'b0)) u_stopFilt (
		.mclk        (mclk),
		.rst         (rst),
		.clkEn       (clkEn),
		.pinIn       (stopPin),
		.pinFiltered (stopFilt)
	);

	// ---------------------------------------------------------------
	// Register port
	// ---------------------------------------------------------------
	// Write-only enables, one bit per key pin
	always_ff @(posedge mclk) begin
		if (rst) begin
			keyEnable_q <= EN_RESET;
		end else if (clkEn && regWr && hitEnable(regAddr)) begin
			keyEnable_q <= regWdata[EN_MSB:EN_LSB];
		end
	end

	// Read returns fixed fill, enables are not visible
	always_ff @(posedge mclk) begin
		if (rst)
			regRdata <= READ_FILL;
		else if (clkEn)
			regRdata <= READ_FILL;
	end

	// Port data path: raw pin level, separate from the detector
	always_ff @(posedge mclk) begin
		if (rst)
			keyPortLevel <= '1;
		else if (clkEn)
			keyPortLevel <= keyPins;
	end

	// ---------------------------------------------------------------
	// Release conditions
	// ---------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst)
			stopFiltPrev_q <= 1'b0;
		else if (clkEn)
			stopFiltPrev_q <= stopFilt;
	end

	// Low level on any enabled key pin
	assign keyRelease   = |(keyEnable_q & ~keyFilt);
	// Dedicated pin needs no enable
	assign levelRelease = stopFilt | keyRelease;
	assign edgeRelease  = stopFilt & ~stopFiltPrev_q;
	assign releaseNow   = (releaseMode == RELM_LEVEL) ? levelRelease : edgeRelease;

	// ---------------------------------------------------------------
	// Stop state control
	// ---------------------------------------------------------------
	// Stop entered by request, left by release
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q     <= ST_RUN;
			warmupStart <= 1'b0;
		end else if (clkEn) begin
			warmupStart <= 1'b0;
			case (state_q)
				ST_RUN: begin
					if (stopRequest) begin
						// Level condition present: skip stop
						if (releaseMode == RELM_LEVEL && levelRelease) begin
							warmupStart <= 1'b1;
						end else begin
							state_q <= ST_STOP;
						end
					end
				end
				ST_STOP: begin
					if (releaseNow) begin
						state_q     <= ST_RUN;
						warmupStart <= 1'b1;
					end
				end
				default: state_q <= ST_RUN;
			endcase
		end
	end

	assign stopActive = (state_q == ST_STOP);

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	a_reset_enables: assert property (@(posedge mclk) rst |=> keyEnable_q == EN_RESET)
		else $error("enables not cleared by reset");
	a_enable_write: assert property (@(posedge mclk) disable iff (rst)
		(clkEn && regWr && regAddr == KEY_WAKE_ENABLE_ADDR)
		|=> keyEnable_q == $past(regWdata[7:4]))
		else $error("enable write not stored");
	a_read_blank: assert property (@(posedge mclk) disable iff (rst)
		(clkEn && regRd) |=> regRdata == READ_FILL)
		else $error("read exposes enables");
	a_key_release: assert property (@(posedge mclk) disable iff (rst)
		(clkEn && state_q == ST_STOP && releaseMode && keyRelease)
		|=> (warmupStart && state_q == ST_RUN))
		else $error("enabled low key did not release");
	a_dedicated_level: assert property (@(posedge mclk) disable iff (rst)
		(clkEn && state_q == ST_STOP && releaseMode && stopFilt) |=> !stopActive)
		else $error("dedicated pin did not release");
	a_edge_nokeys: assert property (@(posedge mclk) disable iff (rst)
		(clkEn && state_q == ST_STOP && !releaseMode && !edgeRelease) |=> stopActive)
		else $error("edge mode released without rising edge");
	a_skip_stop: assert property (@(posedge mclk) disable iff (rst)
		(clkEn && state_q == ST_RUN && stopRequest && releaseMode && levelRelease)
		|=> (warmupStart && !stopActive))
		else $error("stop entered despite release condition");
	a_filter_glitch: assert property (@(posedge mclk) disable iff (rst)
		(clkEn && $rose(u_stopFilt.sync2_q)) ##1 (clkEn && !u_stopFilt.sync2_q)
		|=> $stable(stopFilt))
		else $error("single sample reached release logic");
	a_stop_entry: assert property (@(posedge mclk) disable iff (rst)
		(clkEn && state_q == ST_RUN && stopRequest && !releaseMode) |=> stopActive)
		else $error("stop request not honoured");

	// ---------------------------------------------------------------
	// Further checks
	// ---------------------------------------------------------------

	// Clock enable low freezes the control state
	a_freeze_state: assert property (@(posedge mclk) disable iff (rst)
		!clkEn
		|=> ($stable(state_q) && $stable(keyEnable_q) && $stable(stopFiltPrev_q)))
		else $error("state moved while clock enable low");

	// Warm-up pulse only ever lands in the run state
	a_warm_run: assert property (@(posedge mclk) disable iff (rst)
		warmupStart
		|-> !stopActive)
		else $error("warm-up pulse while still stopped");

	// Edge mode ignores low key pins
	a_edge_keys: assert property (@(posedge mclk) disable iff (rst)
		(clkEn && state_q == ST_STOP && !releaseMode && keyRelease && !edgeRelease)
		|=> stopActive)
		else $error("key pin released stop in edge mode");

	// Port path follows the raw pin one cycle later
	a_port_level: assert property (@(posedge mclk) disable iff (rst)
		clkEn
		|=> keyPortLevel == $past(keyPins))
		else $error("port level does not follow pins");

	// A second stop request while stopped changes nothing
	a_stop_ignored: assert property (@(posedge mclk) disable iff (rst)
		(clkEn && state_q == ST_STOP && stopRequest && !releaseNow)
		|=> stopActive)
		else $error("stop request while stopped left stop");

	// Edge mode never skips stop entry
	a_edge_noskip: assert property (@(posedge mclk) disable iff (rst)
		(clkEn && state_q == ST_RUN && stopRequest && !releaseMode)
		|=> !warmupStart)
		else $error("edge mode skipped stop entry");

	// No warm-up without a request or a release
	a_no_warm: assert property (@(posedge mclk) disable iff (rst)
		(clkEn && state_q == ST_RUN && !stopRequest)
		|=> !warmupStart)
		else $error("spurious warm-up pulse");

	// Run state held until a stop request
	a_run_stays: assert property (@(posedge mclk) disable iff (rst)
		(clkEn && state_q == ST_RUN && !stopRequest)
		|=> !stopActive)
		else $error("stop entered without request");

	// A one-sample dip on a key pin never reaches the detector
	a_key_glitch: assert property (@(posedge mclk) disable iff (rst)
		(clkEn && $fell(g_key[0].u_keyFilt.sync2_q)) ##1 (clkEn && g_key[0].u_keyFilt.sync2_q)
		|=> $stable(keyFilt[0]))
		else $error("single key sample reached release logic");

	// Reset leaves the block running and quiet
	a_reset_outputs: assert property (@(posedge mclk)
		rst
		|=> (!stopActive && !warmupStart && keyPortLevel == {NUM_KEYS{1'b1}}))
		else $error("outputs not at reset values");

	// State register holds a legal code
	a_state_legal: assert property (@(posedge mclk) disable iff (rst)
		(state_q == ST_RUN) ||
		(state_q == ST_STOP))
		else $error("illegal state code");

	// No enables and no dedicated level: stop holds
	a_keys_disabled: assert property (@(posedge mclk) disable iff (rst)
		(clkEn && state_q == ST_STOP && releaseMode && !stopFilt && ~|keyEnable_q)
		|=> stopActive)
		else $error("released with all keys disabled");

	// Level mode holds stop while no condition is present
	a_level_hold: assert property (@(posedge mclk) disable iff (rst)
		(clkEn && state_q == ST_STOP && releaseMode && !levelRelease)
		|=> stopActive)
		else $error("level mode released without condition");

	// Rising dedicated pin in edge mode releases
	a_edge_release: assert property (@(posedge mclk) disable iff (rst)
		(clkEn && state_q == ST_STOP && !releaseMode && edgeRelease)
		|=> (warmupStart && !stopActive))
		else $error("rising edge did not release");

	// Read data stays blank while frozen too
	a_rdata_frozen: assert property (@(posedge mclk) disable iff (rst)
		!clkEn
		|=> regRdata == READ_FILL)
		else $error("read data changed while frozen");

	// Edge detector history tracks the filtered pin
	a_prev_track: assert property (@(posedge mclk) disable iff (rst)
		clkEn
		|=> stopFiltPrev_q == $past(stopFilt))
		else $error("edge history out of step");

	c_key_wake:  cover property (@(posedge mclk) stopActive ##[1:50] (warmupStart && keyRelease));
	c_edge_wake: cover property (@(posedge mclk) stopActive && !releaseMode ##1 warmupStart);
	c_skip:      cover property (@(posedge mclk) state_q == ST_RUN && stopRequest ##1 warmupStart);
	// Dedicated level wake and a frozen stop
	c_ded_wake:  cover property (@(posedge mclk) stopActive && releaseMode && stopFilt ##1 warmupStart);
	c_freeze:    cover property (@(posedge mclk) stopActive && !clkEn ##1 stopActive);
endmodule // key_wakeup_stop_release

/* File: key_wakeup_stop_release_tb_top.sv */
// Self-checking testbench for the key wakeup stop-release block
`timescale 1ns/1ps
module key_wakeup_stop_release_tb_top;
	import kwu_pkg::*;
	logic       mclk, rst, regWr, regRd, relMode, stopReq, stopLvl, stopPin, stopAct, warm;
	logic [15:0] regAddr;
	logic [7:0]  regWdata, regRdata;
	logic [3:0]  keyPress, keyPins, portLvl;
	int          errorCnt, checked;
	logic        clkEn;
	key_switch_model ksm (.mclk(mclk), .keyPress(keyPress), .stopLevel(stopLvl),
		.keyPins(keyPins), .stopPin(stopPin));
	key_wakeup_stop_release DUT (.mclk(mclk), .rst(rst), .clkEn(clkEn), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.releaseMode(relMode), .stopRequest(stopReq), .stopPin(stopPin), .keyPins(keyPins),
		.keyPortLevel(portLvl), .stopActive(stopAct), .warmupStart(warm));
	// ---------------------------------------------------------------
	// Bench tasks
	// ---------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	task automatic chk(string n, logic [7:0] e, logic [7:0] s);
		checked++;
		if (s !== e) begin
			errorCnt++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, errorCnt);
		if (errorCnt == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic wr(logic [15:0] a, logic [7:0] d);
		@(posedge mclk) begin regWr <= 1'b1; regAddr <= a; regWdata <= d; end
		@(posedge mclk) regWr <= 1'b0;
	endtask
	task automatic rd(logic [15:0] a, output logic [7:0] d);
		@(posedge mclk) begin regRd <= 1'b1; regAddr <= a; end
		@(posedge mclk) regRd <= 1'b0;
		@(negedge mclk) d = regRdata;
	endtask
	task automatic stopEntry();
		@(posedge mclk) stopReq <= 1'b1;
		@(posedge mclk) stopReq <= 1'b0;
	endtask
	task automatic idle(int n);
		repeat (n) @(posedge mclk);
	endtask
	// Bounded watch for the warm-up pulse
	task automatic waitWarm(string n, logic e);
		logic seen;
		seen = 1'b0;
		repeat (20) @(negedge mclk) if (warm === 1'b1) seen = 1'b1;
		chk(n, {7'h0, e}, {7'h0, seen});
		if (e && !seen) report_and_stop();
	endtask
	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		logic [7:0] d;
		errorCnt = 0; checked = 0; rst = 1'b1; regWr = 1'b0; regRd = 1'b0; regAddr = 16'h0000;
		clkEn = 1'b1;
		regWdata = 8'h00; relMode = RELM_LEVEL; stopReq = 1'b0; stopLvl = 1'b0; keyPress = 4'h0;
		idle(10);
		rst <= 1'b0;
		@(negedge mclk);
		chk("rdata", 8'h00, regRdata);
		chk("port", 8'h0F, {4'h0, portLvl});
		chk("stop", 8'h00, {7'h0, stopAct});
		// Nothing enabled: key presses must not release
		stopEntry();
		@(negedge mclk) chk("stop", 8'h01, {7'h0, stopAct});
		keyPress <= 4'hF;
		waitWarm("keysOff", 1'b0);
		keyPress <= 4'h0;
		stopLvl <= 1'b1;
		waitWarm("stopLvl", 1'b1);
		stopLvl <= 1'b0;
		idle(10);
		// Enables are write-only, mapped and unmapped reads
		wr(KEY_WAKE_ENABLE_ADDR, 8'hF0);
		rd(KEY_WAKE_ENABLE_ADDR, d);
		chk("rdEn", 8'h00, d);
		rd(16'h0030, d);
		chk("rdOther", 8'h00, d);
		// One enable at a time, a disabled key first
		for (int i = 0; i < 4; i++) begin
			wr(KEY_WAKE_ENABLE_ADDR, 8'h10 << i);
			stopEntry();
			keyPress <= 4'h1 << ((i + 1) % 4);
			waitWarm("keyOff", 1'b0);
			chk("port", {4'h0, ~(4'h1 << ((i + 1) % 4))}, {4'h0, portLvl});
			keyPress <= 4'h1 << i;
			waitWarm("keyOn", 1'b1);
			@(negedge mclk) chk("stop", 8'h00, {7'h0, stopAct});
			keyPress <= 4'h0;
			idle(10);
		end
		// Enabled key already low at stop request: no stop
		wr(KEY_WAKE_ENABLE_ADDR, 8'hF0);
		keyPress <= 4'h2;
		idle(10);
		stopEntry();
		waitWarm("skip", 1'b1);
		chk("stop", 8'h00, {7'h0, stopAct});
		keyPress <= 4'h0;
		// Edge mode: a held-high line does not release, a rise does
		wr(KEY_WAKE_ENABLE_ADDR, 8'h00);
		relMode <= RELM_EDGE;
		stopLvl <= 1'b1;
		idle(10);
		stopEntry();
		waitWarm("edgeHeld", 1'b0);
		stopLvl <= 1'b0;
		idle(10);
		stopLvl <= 1'b1;
		waitWarm("edgeRise", 1'b1);
		// Clock enable low freezes a pending release
		relMode <= RELM_LEVEL;
		stopLvl <= 1'b0;
		idle(10);
		stopEntry();
		clkEn <= 1'b0;
		stopLvl <= 1'b1;
		waitWarm("frozen", 1'b0);
		chk("frzStop", 8'h01, {7'h0, stopAct});
		clkEn <= 1'b1;
		waitWarm("thawed", 1'b1);
		report_and_stop();
	end
endmodule // key_wakeup_stop_release_tb_top

/* File: kwu_pin_filter.sv */
// Synchroniser and majority-free run filter for one wake input
`timescale 1ns/1ps
module kwu_pin_filter
	import kwu_pkg::*;
#(
	parameter int SAMPLES = FILTER_SAMPLES,
	parameter logic INIT  = 1'b1
) (
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic clkEn,
	input  wire logic pinIn,
	output logic      pinFiltered
);
	logic                 sync1_q;
	logic                 sync2_q;
	logic [SAMPLES-1:0]   hist_q;

	// ---------------------------------------------------------------
	// Two-stage synchroniser, then run filter
	// ---------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			sync1_q <= INIT;
			sync2_q <= INIT;
		end else if (clkEn) begin
			sync1_q <= pinIn;
			sync2_q <= sync1_q;
		end
	end

	// Output changes only after SAMPLES equal samples
	always_ff @(posedge mclk) begin
		if (rst) begin
			hist_q      <= {SAMPLES{INIT}};
			pinFiltered <= INIT;
		end else if (clkEn) begin
			hist_q <= {hist_q[SAMPLES-2:0], sync2_q};
			if (&hist_q)
				pinFiltered <= 1'b1;
			else if (~|hist_q)
				pinFiltered <= 1'b0;
		end
	end
endmodule // kwu_pin_filter

/* File: kwu_pkg.sv */
// Package for the key-on wakeup stop-release block
package kwu_pkg;
	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [15:0] KEY_WAKE_ENABLE_ADDR = 16'h0031;
	localparam int          EN_LSB               = 4;
	localparam int          EN_MSB               = 7;
	localparam logic [3:0]  EN_RESET             = 4'h0;
	localparam logic [7:0]  READ_FILL            = 8'h00;
	// ---------------------------------------------------------------
	// Filter and release modes
	// ---------------------------------------------------------------
	localparam int          FILTER_SAMPLES       = 3;
	localparam logic        RELM_EDGE            = 1'b0;
	localparam logic        RELM_LEVEL           = 1'b1;
endpackage : kwu_pkg
